//--- verilog/bcm_pkg.sv
package bcm_pkg;
    localparam logic [3:0] BCM_OP_BIT_CLEAR = 4'h9;
    localparam logic [7:0] BCM_OP_BRANCH_NEG = 8'he6;
    localparam logic [7:0] BCM_OP_MUL_LIT = 8'h0d;
    localparam logic [7:0] BCM_INDEXED_LIMIT = 8'h5f;
    localparam logic [3:0] BCM_ACCESS_BANK_LO = 4'h0;
    localparam logic [3:0] BCM_ACCESS_BANK_HI = 4'hf;
    localparam logic [7:0] BCM_ACCESS_SPLIT = 8'h60;
    localparam logic [20:0] BCM_PC_RESET = 21'h000000;
    localparam logic [7:0] BCM_PROD_RESET = 8'h00;
    localparam logic [20:0] BCM_PC_STEP = 21'h000002;
    typedef enum logic [1:0] {BCM_Q1, BCM_Q2, BCM_Q3, BCM_Q4} bcm_quarter_t;
endpackage : bcm_pkg

//--- verilog/bcm_mul8.sv
`timescale 1ns/1ps
// registered 8x8 unsigned multiply; product captured on load pulse
module bcm_mul8
    import bcm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [7:0] wreg_i,
    input wire logic [7:0] lit_i,
    output logic [7:0] prod_hi_o,
    output logic [7:0] prod_lo_o
);
    logic [15:0] prod_reg;
    logic [15:0] prod_next;

    always_comb begin
        prod_next = prod_reg;
        if (load_i) begin
            prod_next = 16'(wreg_i) * 16'(lit_i);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            prod_reg <= {BCM_PROD_RESET, BCM_PROD_RESET};
        end else begin
            prod_reg <= prod_next;
        end
    end

    assign prod_hi_o = prod_reg[15:8];
    assign prod_lo_o = prod_reg[7:0];

    prod_value_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        load_i |=> prod_reg == $past(wreg_i) * $past(lit_i))
        else $error("product does not match operands");
endmodule : bcm_mul8

//--- verilog/bcm_exec.sv
`timescale 1ns/1ps
// Contract
// - bit-clear (1001 prefix) zeroes the chosen bit, keeps all other bits.
// - access operand 0 uses access bank; 1 uses bank select register.
// - extended set, access 0, address <= 95 uses indexed literal offset.
// - branch-on-negative (1110 0110) jumps only if negative flag set; flags untouched.
// - taken branch loads PC with branch address plus two plus twice offset.
// - taken branch lasts two cycles, second a no-op; untaken one, no write.
// - multiply-literal is unsigned 8x8 giving a 16-bit result.
// - product high byte to high register, low byte to low register.
// - multiply-literal recognised by 0000 1101 upper byte; lower byte is literal.
// - configuration bit enables extended set and indexed addressing; clear is legacy.
module bcm_exec
    import bcm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic extended_set_enable_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [20:0] instr_addr_i,
    input wire logic negative_flag_i,
    input wire logic [7:0] wreg_i,
    input wire logic [3:0] bank_select_reg_i,
    input wire logic [11:0] index_base_i,
    input wire logic [7:0] file_rdata_i,
    output logic [11:0] file_addr_o,
    output logic file_we_o,
    output logic [7:0] file_wdata_o,
    output logic pc_we_o,
    output logic [20:0] pc_next_o,
    output logic busy_o,
    output logic instr_ack_o,
    output logic [7:0] product_high_byte_o,
    output logic [7:0] product_low_byte_o,
    output logic flags_we_o
);
    bcm_quarter_t q_reg;
    bcm_quarter_t q_next;
    logic [15:0] ir_reg;
    logic [15:0] ir_next;
    logic [20:0] ia_reg;
    logic [20:0] ia_next;
    logic nop_reg;
    logic nop_next;
    logic extended_set_enable_reg;
    logic extended_set_enable_next;
    logic [11:0] addr_reg;
    logic [11:0] addr_next;
    logic fwe_reg;
    logic fwe_next;
    logic [7:0] fwd_reg;
    logic [7:0] fwd_next;
    logic pwe_reg;
    logic pwe_next;
    logic [20:0] pc_reg;
    logic [20:0] pc_next;
    logic ack_reg;
    logic ack_next;
    logic is_bcf;
    logic is_bn;
    logic is_mul;
    logic mul_load;
    logic [11:0] ea;

    // opcode decode on the latched instruction word
    assign is_bcf = ir_reg[15:12] == BCM_OP_BIT_CLEAR;
    assign is_bn = ir_reg[15:8] == BCM_OP_BRANCH_NEG;
    assign is_mul = ir_reg[15:8] == BCM_OP_MUL_LIT;

    // effective data address for bit-clear
    always_comb begin
        ea = {bank_select_reg_i, ir_reg[7:0]};
        if (!ir_reg[8]) begin
            if (extended_set_enable_reg && ir_reg[7:0] <= BCM_INDEXED_LIMIT) begin
                ea = index_base_i + 12'(ir_reg[7:0]);
            end else if (ir_reg[7:0] < BCM_ACCESS_SPLIT) begin
                ea = {BCM_ACCESS_BANK_LO, ir_reg[7:0]};
            end else begin
                ea = {BCM_ACCESS_BANK_HI, ir_reg[7:0]};
            end
        end
    end

    // one instruction cycle is four quarters; a taken branch adds a no-op cycle
    always_comb begin
        q_next = q_reg;
        ir_next = ir_reg;
        ia_next = ia_reg;
        nop_next = nop_reg;
        addr_next = addr_reg;
        fwe_next = 1'b0;
        fwd_next = fwd_reg;
        pwe_next = 1'b0;
        pc_next = pc_reg;
        ack_next = 1'b0;
        mul_load = 1'b0;
        extended_set_enable_next = extended_set_enable_reg;
        unique case (q_reg)
            BCM_Q1: begin
                if (instr_valid_i || nop_reg) begin
                    q_next = BCM_Q2;
                    if (!nop_reg) begin
                        ir_next = instr_i;
                        ia_next = instr_addr_i;
                        // taken with the word so a mid-instruction change cannot split modes
                        extended_set_enable_next = extended_set_enable_i;
                    end
                end
            end
            BCM_Q2: begin
                q_next = BCM_Q3;
                if (!nop_reg && is_bcf) begin
                    addr_next = ea;
                end
            end
            BCM_Q3: begin
                q_next = BCM_Q4;
                if (!nop_reg && is_bcf) begin
                    fwd_next = file_rdata_i & ~(8'h01 << ir_reg[11:9]);
                    fwe_next = 1'b1;
                end
                if (!nop_reg && is_mul) begin
                    mul_load = 1'b1;
                end
                if (!nop_reg && is_bn && negative_flag_i) begin
                    pc_next = ia_reg + BCM_PC_STEP
                        + 21'({{13{ir_reg[7]}}, ir_reg[7:0]} << 1);
                    pwe_next = 1'b1;
                end
            end
            BCM_Q4: begin
                q_next = BCM_Q1;
                nop_next = !nop_reg && pwe_reg;
                ack_next = !nop_reg;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            q_reg <= BCM_Q1;
            ir_reg <= 16'h0000;
            ia_reg <= BCM_PC_RESET;
            nop_reg <= 1'b0;
            extended_set_enable_reg <= 1'b0;
            addr_reg <= 12'h000;
            fwe_reg <= 1'b0;
            fwd_reg <= 8'h00;
            pwe_reg <= 1'b0;
            pc_reg <= BCM_PC_RESET;
            ack_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
            ir_reg <= ir_next;
            ia_reg <= ia_next;
            nop_reg <= nop_next;
            extended_set_enable_reg <= extended_set_enable_next;
            addr_reg <= addr_next;
            fwe_reg <= fwe_next;
            fwd_reg <= fwd_next;
            pwe_reg <= pwe_next;
            pc_reg <= pc_next;
            ack_reg <= ack_next;
        end
    end

    bcm_mul8 u_mul (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(mul_load),
        .wreg_i(wreg_i),
        .lit_i(ir_reg[7:0]),
        .prod_hi_o(product_high_byte_o),
        .prod_lo_o(product_low_byte_o)
    );

    assign file_addr_o = addr_reg;
    assign file_we_o = fwe_reg;
    assign file_wdata_o = fwd_reg;
    assign pc_we_o = pwe_reg;
    assign pc_next_o = pc_reg;
    assign busy_o = q_reg != BCM_Q1 || nop_reg;
    assign instr_ack_o = ack_reg;
    // none of these three instructions touch status or working register
    assign flags_we_o = 1'b0;

    bit_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        file_we_o |-> (file_wdata_o & (8'h01 << ir_reg[11:9])) == 8'h00)
        else $error("bit-clear left selected bit set");
    branch_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pc_we_o |-> $past(negative_flag_i) && is_bn)
        else $error("pc written without taken branch");
    branch_target_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pc_we_o |-> pc_next_o == 21'(ia_reg + 21'd2 + 21'({{13{ir_reg[7]}}, ir_reg[7:0]} << 1)))
        else $error("branch target wrong");
    branch_nop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pc_we_o |-> ##2 nop_reg ##1 !pc_we_o [*4])
        else $error("taken branch lacks no-op cycle");
    indexed_addr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (q_reg == BCM_Q2 && is_bcf && !nop_reg && !ir_reg[8] && extended_set_enable_reg
            && ir_reg[7:0] <= 8'h5f) |=> file_addr_o == $past(index_base_i) + 12'($past(ir_reg[7:0])))
        else $error("indexed address wrong");
    bank_addr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (q_reg == BCM_Q2 && is_bcf && !nop_reg && ir_reg[8])
            |=> file_addr_o == {$past(bank_select_reg_i), $past(ir_reg[7:0])})
        else $error("banked address wrong");
    one_cycle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (q_reg == BCM_Q1 && instr_valid_i && !nop_reg) |-> ##3 instr_ack_o == 1'b0 ##1 instr_ack_o)
        else $error("instruction not acked after four quarters");
    no_flags_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !flags_we_o)
        else $error("flags written");
    branch_skip_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (q_reg == BCM_Q3 && is_bn && !nop_reg && !negative_flag_i) |=> !pc_we_o ##1 !nop_reg)
        else $error("untaken branch wrote pc or idled");
    access_bank_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (q_reg == BCM_Q2 && is_bcf && !nop_reg && !ir_reg[8] && !extended_set_enable_reg)
            |=> file_addr_o[7:0] == $past(ir_reg[7:0])
            && file_addr_o[11:8] == (($past(ir_reg[7:0]) < 8'h60) ? 4'h0 : 4'hf))
        else $error("legacy access bank address wrong");
    ack_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        instr_ack_o |=> !instr_ack_o)
        else $error("acknowledge longer than one cycle");
endmodule : bcm_exec

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import bcm_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ext = 1'b0, valid = 1'b0, neg = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [20:0] iaddr = 21'h000000;
    logic [7:0] wreg = 8'h00;
    logic [3:0] bank_select_reg = 4'h0;
    logic [11:0] ibase = 12'h000;
    logic [11:0] faddr;
    logic [7:0] rdata, fwdata, phi, plo;
    logic fwe, pcwe, busy, ack, flwe;
    logic [20:0] pcn;
    // read-only memory: a missed clear cannot be hidden by a write-back
    logic [7:0] mem [4096];
    logic [59:0] exp_q[$];
    logic [11:0] e_addr = 12'h000;
    logic [7:0] e_wdata = 8'h00;
    logic [20:0] e_pc = 21'h000000;
    logic [15:0] e_prod = 16'h0000;
    logic s_we = 1'b0, s_pc = 1'b0, s_fl = 1'b0;
    logic [31:0] rnd = 32'h75d3;
    int n_errors = 0;
    int checked = 0;
    always #50 core_clk_i = ~core_clk_i;
    assign rdata = mem[faddr];
    bcm_exec dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .extended_set_enable_i(ext),
        .instr_valid_i(valid), .instr_i(instr), .instr_addr_i(iaddr), .negative_flag_i(neg),
        .wreg_i(wreg), .bank_select_reg_i(bank_select_reg), .index_base_i(ibase), .file_rdata_i(rdata),
        .file_addr_o(faddr), .file_we_o(fwe), .file_wdata_o(fwdata), .pc_we_o(pcwe),
        .pc_next_o(pcn), .busy_o(busy), .instr_ack_o(ack), .product_high_byte_o(phi),
        .product_low_byte_o(plo), .flags_we_o(flwe));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [59:0] g, input logic [59:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic final_report;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    // valid stays up while busy, so refusal during busy is exercised too
    task automatic issue(input logic [15:0] ins, input logic [59:0] e, input int noop,
            input bit first);
        int k;
        int cnt;
        k = 0;
        cnt = 0;
        instr = ins;
        valid = 1'b1;
        exp_q.push_back(e);
        do begin
            @(posedge core_clk_i);
            #1;
            k++;
        end while (busy !== 1'b1 && k < 20);
        if (!first) chk(60'(k), 60'd1);
        repeat (3) @(posedge core_clk_i);
        #1;
        // the no-op cycle is already under way once the fourth quarter ends
        for (int j = 0; j < noop; j++) begin
            if (busy === 1'b1) cnt++;
            @(posedge core_clk_i);
            #1;
        end
        chk(60'(cnt), 60'(noop));
        chk(60'(busy), 60'd0);
    endtask : issue
    // sampled mid-cycle, well clear of the edge that launches the outputs
    always @(negedge core_clk_i) begin
        if (rst_n_i === 1'b1) begin
            if (fwe === 1'b1) s_we = 1'b1;
            if (pcwe === 1'b1) s_pc = 1'b1;
            if (flwe !== 1'b0) s_fl = 1'b1;
            if (ack === 1'b1) begin
                if (exp_q.size() == 0) begin
                    n_errors++;
                    $display("[FAIL] t=%0t ack=%h exp=%h", $time, ack, 1'b0);
                end else begin
                    chk({s_we, s_pc, s_fl, faddr, fwdata, pcn, phi, plo},
                        exp_q.pop_front());
                end
                s_we = 1'b0;
                s_pc = 1'b0;
                s_fl = 1'b0;
            end
        end
    end
    initial begin
        #200000;
        n_errors++;
        final_report();
    end
    initial begin
        logic [7:0] v;
        logic [7:0] lim [5];
        logic [15:0] ins;
        logic wb, pw;
        int noop;
        lim = '{8'h5f, 8'h60, 8'h80, 8'hff, 8'h7f};
        for (int j = 0; j < 4096; j++) begin
            rnd = lfsr(rnd);
            mem[j] = rnd[7:0];
        end
        repeat (16) @(posedge core_clk_i);
        #1;
        rst_n_i = 1'b1;
        for (int i = 0; i < 60; i++) begin
            rnd = lfsr(rnd);
            {neg, wreg, ibase, bank_select_reg, ext} = rnd[25:0];
            iaddr = {rnd[31:12], 1'b0};
            rnd = lfsr(rnd);
            v = (i < 40) ? lim[(i / 4) % 5] : rnd[7:0];
            wb = 1'b0;
            pw = 1'b0;
            noop = 0;
            case (i % 4)
                0: begin
                    ins = {BCM_OP_BIT_CLEAR, rnd[10:8], rnd[11], v};
                    e_addr = rnd[11] ? {bank_select_reg, v} :
                        (ext && v <= BCM_INDEXED_LIMIT) ? ibase + 12'(v) :
                        {(v < BCM_ACCESS_SPLIT) ? BCM_ACCESS_BANK_LO : BCM_ACCESS_BANK_HI, v};
                    e_wdata = mem[e_addr] & ~(8'h01 << rnd[10:8]);
                    wb = 1'b1;
                end
                1: begin
                    ins = {BCM_OP_BRANCH_NEG, v};
                    if (neg) begin
                        e_pc = iaddr + BCM_PC_STEP + {{12{v[7]}}, v, 1'b0};
                        pw = 1'b1;
                        noop = 4;
                    end
                end
                2: begin
                    ins = {BCM_OP_MUL_LIT, v};
                    e_prod = 16'(wreg) * 16'(v);
                end
                default: ins = {8'hff, v};
            endcase
            issue(ins, {wb, pw, 1'b0, e_addr, e_wdata, e_pc, e_prod}, noop, i == 0);
        end
        valid = 1'b0;
        repeat (8) @(posedge core_clk_i);
        #1;
        chk(60'(exp_q.size()), 60'd0);
        final_report();
    end
endmodule : tb_top
